// file: src/phys_filter_defs.svh
`ifndef PHYS_FILTER_DEFS_SVH
`define PHYS_FILTER_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MASK_HIGH_SET 12'h110
`define OFS_MASK_HIGH_CLEAR 12'h114
`define OFS_MASK_LOW_SET 12'h118
`define OFS_MASK_LOW_CLEAR 12'h11C
`define OFS_UPPER_BOUND 12'h120

// ****************************************
// reset values and field positions
// ****************************************
`define MASK_RESET 32'h00000000
`define UPPER_BOUND_VALUE 32'h00000000
`define REMOTE_BUS_BIT 31
`define HIGH_NODE_BASE 32
`define LOCAL_BUS_ID 10'h3FF

`endif

// file: src/phys_filter_pkg.sv
package phys_filter_pkg;
    // request routing decision
    typedef enum logic [1:0] {
        ROUTE_PHYS = 2'b01,
        ROUTE_ASYNC = 2'b10
    } route_t;
    typedef logic [11:0] reg_addr_t;
    typedef logic [31:0] reg_word_t;
endpackage

// file: src/node_mask_reg.sv
`timescale 1ns/100ps
`default_nettype none
`include "phys_filter_defs.svh"

// set/clear mask register, one word
module node_mask_reg #(
    parameter int WIDTH = 32
) (
    input wire logic sys_clk, // clock
    input wire logic reset, // sync reset
    input wire logic set_en, // write to set address
    input wire logic clear_en, // write to clear address
    input wire logic [WIDTH-1:0] wr_data, // bus write data
    output logic [WIDTH-1:0] mask // current mask
);
    logic [WIDTH-1:0] next_mask; // value after this edge

    // ones set or clear, zeros leave bits alone; strobes never coincide
    assign next_mask = set_en ? (mask | wr_data) : (clear_en ? (mask & ~wr_data) : mask); // R10

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask <= WIDTH'(`MASK_RESET); // R5 R7
        end else begin
            mask <= next_mask;
        end
    end
endmodule
`default_nettype wire

// file: src/physical_request_node_filter.sv
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "phys_filter_defs.svh"

// Functional notes
// R1 - high mask bits 18..0 grant nodes 50..32
// R2 - low mask bit k grants node k
// R3 - recheck sender against mask after async filter
// R4 - clear bit sends request to async context
// R5 - low mask set 118h, clear 11Ch, resets zero
// R6 - upper bound 120h reads zero, ignores writes
// R7 - high mask set 110h, clear 114h, resets zero
// R8 - high bit 31 accepts remote bus nodes
// R9 - high bits 30..19 grant nodes 62..51
// R10 - write ones sets/clears; reads return mask
module physical_request_node_filter (
    input wire logic sys_clk, // 200 MHz register clock
    input wire logic reset, // sync, active high
    input wire phys_filter_pkg::reg_addr_t reg_addr, // byte address
    input wire phys_filter_pkg::reg_word_t reg_wdata, // write data
    input wire logic reg_write, // write strobe
    input wire logic reg_read, // read strobe
    output phys_filter_pkg::reg_word_t reg_rdata, // read data, cycle after strobe
    input wire logic req_valid, // request aimed at physical context
    input wire logic async_pass, // async filter accepted it
    input wire logic [15:0] req_source_id, // sender bus id and node number
    output logic route_valid, // decision valid, one cycle
    output phys_filter_pkg::route_t route_sel, // physical or async context
    output logic route_reject // dropped by async filter
);
    import phys_filter_pkg::*;

    // ****************************************
    // address decode
    // ****************************************
    logic hit_high_set; // high mask set address
    logic hit_high_clear; // high mask clear address
    logic hit_low_set; // low mask set address
    logic hit_low_clear; // low mask clear address
    logic hit_bound; // upper bound stub
    assign hit_high_set = (reg_addr == `OFS_MASK_HIGH_SET); // R7
    assign hit_high_clear = (reg_addr == `OFS_MASK_HIGH_CLEAR); // R7
    assign hit_low_set = (reg_addr == `OFS_MASK_LOW_SET); // R5
    assign hit_low_clear = (reg_addr == `OFS_MASK_LOW_CLEAR); // R5
    assign hit_bound = (reg_addr == `OFS_UPPER_BOUND);

    // ****************************************
    // mask storage
    // ****************************************
    reg_word_t phys_node_mask_high; // nodes 62..32 plus remote bit
    reg_word_t phys_node_mask_low; // nodes 31..0

    node_mask_reg #(.WIDTH(32)) high_mask (
        .sys_clk(sys_clk),
        .reset(reset),
        .set_en(reg_write && hit_high_set),
        .clear_en(reg_write && hit_high_clear),
        .wr_data(reg_wdata),
        .mask(phys_node_mask_high)
    );

    node_mask_reg #(.WIDTH(32)) low_mask (
        .sys_clk(sys_clk),
        .reset(reset),
        .set_en(reg_write && hit_low_set),
        .clear_en(reg_write && hit_low_clear),
        .wr_data(reg_wdata),
        .mask(phys_node_mask_low)
    );

    // ****************************************
    // read mux
    // ****************************************
    // writes to the bound stub hit no storage at all
    reg_word_t read_word; // selected word
    assign read_word = (hit_high_set || hit_high_clear) ? phys_node_mask_high : // R10
                       (hit_low_set || hit_low_clear) ? phys_node_mask_low : // R10
                       hit_bound ? `UPPER_BOUND_VALUE : // R6
                       32'h00000000; // unmapped reads zero

    // data held only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_read ? read_word : 32'h00000000;
        end
    end

    // ****************************************
    // node lookup
    // ****************************************
    // node 63 is broadcast and has no grant bit
    function automatic logic node_granted(input logic [5:0] node, input reg_word_t lo, input reg_word_t hi);
        if (node < 6'(`HIGH_NODE_BASE)) begin
            node_granted = lo[node[4:0]]; // R2
        end else if (node == 6'h3F) begin
            node_granted = 1'b0;
        end else begin
            node_granted = hi[node[4:0]]; // R1 R9
        end
    endfunction

    logic is_local; // sender on our bus
    logic grant; // mask allows physical handling
    assign is_local = (req_source_id[15:6] == `LOCAL_BUS_ID);
    assign grant = is_local ? node_granted(req_source_id[5:0], phys_node_mask_low, phys_node_mask_high)
                            : phys_node_mask_high[`REMOTE_BUS_BIT]; // R8

    // ****************************************
    // routing decision
    // ****************************************
    // second check only runs after the async filter passed
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            route_valid <= 1'b0;
            route_sel <= ROUTE_ASYNC;
            route_reject <= 1'b0;
        end else begin
            route_valid <= req_valid; // R3
            route_reject <= req_valid && !async_pass;
            route_sel <= (async_pass && grant) ? ROUTE_PHYS : ROUTE_ASYNC; // R3 R4
        end
    end
endmodule
`default_nettype wire

// file: verification/phys_filter_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// port-level watcher for the node filter
module phys_filter_asserts import phys_filter_pkg::*; (
    input wire logic sys_clk, reset, reg_write, reg_read, req_valid, async_pass, // inputs
    input wire reg_addr_t reg_addr, // byte address
    input wire reg_word_t reg_wdata, reg_rdata, // bus data
    input wire logic [15:0] req_source_id, // sender id
    input wire logic route_valid, route_reject, // decision pulses
    input wire route_t route_sel // chosen context
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    chk_route_follows: assert property (req_valid |=> route_valid) else $error("no decision");
    chk_route_spurious: assert property (!req_valid |=> !route_valid) else $error("stray decision");
    chk_reject_async: assert property (req_valid && !async_pass |=> route_reject && route_sel == ROUTE_ASYNC)
        else $error("reject not async");
    chk_pass_kept: assert property (req_valid && async_pass |=> !route_reject) else $error("false reject");
    chk_bound_zero: assert property (reg_read && reg_addr == 12'h120 |=> reg_rdata == '0) else $error("bound");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == '0) else $error("rdata idle");
    chk_set_bits: assert property (reg_write && (reg_addr == 12'h110 || reg_addr == 12'h118) ##1 reg_read
        && reg_addr == $past(reg_addr) |=> (reg_rdata & $past(reg_wdata, 2)) == $past(reg_wdata, 2))
        else $error("set lost");
    chk_clear_bits: assert property (reg_write && (reg_addr == 12'h114 || reg_addr == 12'h11C) ##1 reg_read
        && reg_addr == $past(reg_addr) |=> (reg_rdata & $past(reg_wdata, 2)) == '0) else $error("clear");
    chk_reset_clean: assert property (disable iff (1'b0) reset |=> reg_rdata == '0 && !route_valid)
        else $error("reset");
    cover property (route_valid && route_sel == ROUTE_PHYS);
    cover property (route_reject);
    cover property (reg_write && reg_addr == 12'h11C);
endmodule
bind physical_request_node_filter phys_filter_asserts i_phys_filter_asserts (.*);
`default_nettype wire

// file: verification/remote_node_model.sv
`timescale 1ns/100ps
`default_nettype none
// remote node: one physical request at a time
module remote_node_model (
    input wire logic sys_clk, // clock
    output logic req_valid, // request pulse
    output logic async_pass, // async filter verdict
    output logic [15:0] req_source_id // sender id
);
    initial begin
        req_valid = 1'b0;
        async_pass = 1'b0;
        req_source_id = 16'h0000;
    end
    // inputs are inverted afterwards so a stale id is never trusted
    task send(input logic [15:0] id, input logic p);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        async_pass <= p;
        req_source_id <= id;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        async_pass <= ~p;
        req_source_id <= ~id;
    endtask
endmodule
`default_nettype wire

// file: verification/physical_request_node_filter_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module physical_request_node_filter_tb_top;
    import phys_filter_pkg::*;
    logic sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, req_valid, async_pass, route_valid, route_reject;
    reg_addr_t reg_addr = '0, a;
    reg_word_t reg_wdata = '0, reg_rdata, lo = '0, hi = '0, x, d;
    logic [15:0] req_source_id;
    route_t route_sel;
    logic [31:0] seed = 32'h77BCC7FF;
    int fails = 0, tests_run = 0, cyc = 0;
    physical_request_node_filter i_physical_request_node_filter (.*);
    remote_node_model i_remote_node_model (.*);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // hang guard, far beyond the run length
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected grant: remote bus, low node, node 63, high node
    function automatic logic grant(logic [15:0] i);
        if (i[15:6] != 10'h3FF) return hi[31];
        if (i[5:0] == 6'h3F) return 1'b0;
        return i[5] ? hi[i[4:0]] : lo[i[4:0]];
    endfunction
    task chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task bus(input logic w, r, input reg_addr_t ad, input reg_word_t v);
        @(posedge sys_clk);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= ad;
        reg_wdata <= v;
    endtask
    task rd(input reg_addr_t ad, input reg_word_t e);
        bus(0, 1, ad, xs());
        bus(0, 0, ad, 0);
        #1 chk("rdata", reg_rdata, e);
    endtask
    task req(input logic [15:0] i, input logic p);
        i_remote_node_model.send(i, p);
        #1 chk("route", {route_valid, route_reject, route_sel}, {1'b1, !p, (p && grant(i)) ? ROUTE_PHYS : ROUTE_ASYNC});
    endtask
    task summarize;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 0;
        rd(12'h110, 0);
        rd(12'h118, 0);
        bus(1, 0, 12'h120, '1);
        rd(12'h120, 0);
        bus(1, 0, 12'h200, '1);
        rd(12'h200, 0);
        $display("test reset done");
        repeat (80) begin
            d = xs();
            x = xs();
            a = 12'h110 | {8'h00, d[1:0], 2'b00};
            if (a[3]) lo = a[2] ? lo & ~x : lo | x;
            else hi = a[2] ? hi & ~x : hi | x;
            bus(1, 0, a, x);
            rd(a, a[3] ? lo : hi);
            req({d[16] ? 10'h3FF : d[31:22], d[5:0]}, d[8]);
        end
        bus(1, 0, 12'h110, '1);
        bus(0, 0, 12'h110, 0);
        hi = '1;
        req(16'hFFFF, 1);
        $display("test random done");
        summarize();
    end
endmodule
`default_nettype wire
